// ===== ees_cfg.svh
// Constants of the two-wire serial memory slave
`ifndef EES_CFG_SVH
`define EES_CFG_SVH
`define EES_TYPE_CODE   4'ha
`define EES_ADDR_W      17
`define EES_PAGE_W      8
`define EES_ERASED      8'hff
`define EES_BIT_LAST    4'h7
`define EES_BIT_ACK     4'h8
`define EES_DEV_RW      0
`define EES_DEV_TOP     1
`define EES_DEV_CS_LO   2
`define EES_DEV_CS_HI   3
`define EES_TWR_US      5000
`define EES_CLK_KHZ     10000
`define EES_TWR_CYCLES  (`EES_TWR_US * `EES_CLK_KHZ / 1000)
`define EES_WR_MIN      16
`endif

// ===== ees_pkg.sv
// Types of the two-wire serial memory slave
package ees_pkg;
  typedef enum logic [2:0] {
    st_idle  = 3'h0,
    st_dev   = 3'h1,
    st_ahi   = 3'h2,
    st_alo   = 3'h3,
    st_wdata = 3'h4,
    st_rdata = 3'h5
  } ees_state_type;
endpackage

// ===== ees_sync3.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module ees_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             en,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] r1;
  logic [WIDTH-1:0] r2;
  logic [WIDTH-1:0] r3;
  logic [WIDTH-1:0] next_q;

  if (WIDTH < 1) begin : g_bad_width
    $error("ees_sync3: WIDTH must be at least 1");
  end

  always_comb begin
    next_q = (r2 == r3) ? r3 : q;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r1 <= '0;
      r2 <= '0;
      r3 <= '0;
      q  <= '0;
    end else if (en) begin
      r1 <= d;
      r2 <= r1;
      r3 <= r2;
      q  <= next_q;
    end
  end
endmodule

// ===== ees_cond.sv
// Bus condition detector: data-line edges while the clock line is high
`timescale 1ns/1ns
module ees_cond (
  input  wire logic rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic write_pending,
  output logic      start_tgl,
  output logic      prog_tgl
);
  // Falling data with clock high marks a start
  always_ff @(negedge sda_in or posedge rst) begin
    if (rst) begin
      start_tgl <= 1'b0;
    end else if (scl_in) begin
      start_tgl <= ~start_tgl;
    end
  end

  // Rising data with clock high marks a stop; only a written stop programs
  always_ff @(posedge sda_in or posedge rst) begin
    if (rst) begin
      prog_tgl <= 1'b0;
    end else if (scl_in && write_pending) begin
      prog_tgl <= ~prog_tgl;
    end
  end
endmodule

// ===== ees_slave.sv
// Two-wire serial memory slave: protocol, array and write-cycle timer
`timescale 1ns/1ns
`include "ees_cfg.svh"
module ees_slave
  import ees_pkg::*;
#(
  parameter int WR_CYCLES = `EES_TWR_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  input  wire logic chip_select_low_pin,
  input  wire logic chip_select_high_pin,
  input  wire logic write_protect,
  output logic      busy
);
  localparam int AW = `EES_ADDR_W;
  localparam int PW = `EES_PAGE_W;
  localparam int TW = $clog2(WR_CYCLES + 1);

  if (WR_CYCLES < `EES_WR_MIN) begin : g_bad_wr
    $error("ees_slave: WR_CYCLES too small");
  end

  // ==========================================================
  // Bus conditions and crossings
  logic start_tgl;
  logic prog_tgl;
  logic write_pending;
  logic prog_sync;
  logic busy_s;

  ees_cond u_cond (
    .rst           (rst),
    .scl_in        (scl_in),
    .sda_in        (sda_in),
    .write_pending (write_pending),
    .start_tgl     (start_tgl),
    .prog_tgl      (prog_tgl)
  );

  ees_sync3 #(.WIDTH(1)) u_prog_sync (
    .clock (clock),
    .rst   (rst),
    .en    (ce),
    .d     (prog_tgl),
    .q     (prog_sync)
  );

  ees_sync3 #(.WIDTH(1)) u_busy_sync (
    .clock (scl_in),
    .rst   (rst),
    .en    (1'b1),
    .d     (busy),
    .q     (busy_s)
  );

  // ==========================================================
  // Link side, rising clock edge: shifting and decoding
  ees_state_type state;
  ees_state_type next_state;
  logic [3:0]    cnt;
  logic [3:0]    next_cnt;
  logic [6:0]    shreg;
  logic [6:0]    next_shreg;
  logic [AW-1:0] addr;
  logic [AW-1:0] next_addr;
  logic          ack_go;
  logic          next_ack_go;
  logic          first;
  logic          next_first;
  logic          next_write_pending;
  logic [7:0]    tx_byte;
  logic [7:0]    next_tx_byte;
  logic          start_ref;
  logic          is_start;
  logic [7:0]    byte_in;
  logic          dev_ok;
  logic          mem_we;
  logic          wp_lat;
  logic [7:0]    mem [2**AW];

  assign is_start = start_tgl != start_ref;
  assign byte_in  = {shreg, sda_in};
  assign dev_ok   = byte_in[7:4] == `EES_TYPE_CODE
                 && byte_in[`EES_DEV_CS_HI] == chip_select_high_pin
                 && byte_in[`EES_DEV_CS_LO] == chip_select_low_pin;

  always_comb begin
    next_state         = state;
    next_cnt           = cnt;
    next_shreg         = shreg;
    next_addr          = addr;
    next_ack_go        = ack_go;
    next_first         = first;
    next_write_pending = write_pending;
    next_tx_byte       = tx_byte;
    mem_we             = 1'b0;
    if (is_start) begin
      // A start aborts anything in progress, repeated or not
      next_state         = st_dev;
      next_cnt           = 4'h1;
      next_shreg         = {6'h00, sda_in};
      next_ack_go        = 1'b0;
      next_write_pending = 1'b0;
    end else if (state != st_idle) begin
      if (cnt < `EES_BIT_LAST) begin
        next_shreg = byte_in[6:0];
        next_cnt   = cnt + 4'h1;
      end else if (cnt == `EES_BIT_LAST) begin
        next_cnt = `EES_BIT_ACK;
        case (state)
          st_dev: begin
            if (dev_ok && !busy_s) begin
              next_ack_go = 1'b1;
              if (byte_in[`EES_DEV_RW]) begin
                next_state = st_rdata;
                next_first = 1'b1;
              end else begin
                next_addr[AW-1] = byte_in[`EES_DEV_TOP];
                next_state      = st_ahi;
              end
            end else begin
              next_ack_go = 1'b0;
              next_state  = st_idle;
            end
          end
          st_ahi: begin
            next_addr[AW-2:PW] = byte_in;
            next_ack_go        = 1'b1;
            next_state         = st_alo;
          end
          st_alo: begin
            next_addr[PW-1:0] = byte_in;
            next_ack_go       = 1'b1;
            next_state        = st_wdata;
            next_first        = 1'b1;
          end
          st_wdata: begin
            if (first && wp_lat) begin
              next_ack_go = 1'b0;
              next_state  = st_idle;
            end else begin
              mem_we             = 1'b1;
              next_ack_go        = 1'b1;
              next_addr[PW-1:0]  = addr[PW-1:0] + 8'h01;
              next_write_pending = 1'b1;
              next_first         = 1'b0;
            end
          end
          default: begin
            next_ack_go = 1'b0;
          end
        endcase
      end else begin
        next_cnt    = 4'h0;
        next_ack_go = 1'b0;
        if (state == st_rdata) begin
          if (first || !sda_in) begin
            next_tx_byte = mem[addr];
            next_addr    = addr + 17'h00001;
            next_first   = 1'b0;
          end else begin
            next_state = st_idle;
          end
        end
      end
    end
  end

  always_ff @(posedge scl_in or posedge rst) begin
    if (rst) begin
      state         <= st_idle;
      cnt           <= 4'h0;
      shreg         <= 7'h00;
      addr          <= '0;
      ack_go        <= 1'b0;
      first         <= 1'b0;
      write_pending <= 1'b0;
      tx_byte       <= `EES_ERASED;
      start_ref     <= 1'b0;
    end else begin
      state         <= next_state;
      cnt           <= next_cnt;
      shreg         <= next_shreg;
      addr          <= next_addr;
      ack_go        <= next_ack_go;
      first         <= next_first;
      write_pending <= next_write_pending;
      tx_byte       <= next_tx_byte;
      start_ref     <= start_tgl;
    end
  end

  // ==========================================================
  // Array storage, written as each data byte is accepted
  always_ff @(posedge scl_in or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem[i] <= `EES_ERASED;
      end
    end else if (mem_we) begin
      mem[addr] <= byte_in;
    end
  end

  // ==========================================================
  // Link side, falling clock edge: driving the data pin
  logic next_oe_n;
  logic next_wp_lat;

  always_comb begin
    next_oe_n   = 1'b1;
    next_wp_lat = wp_lat;
    if (cnt == `EES_BIT_ACK && ack_go) begin
      next_oe_n = 1'b0;
    end else if (state == st_rdata && cnt < `EES_BIT_ACK && !first) begin
      next_oe_n = tx_byte[3'(`EES_BIT_LAST - cnt)];
    end
    if (state == st_wdata && cnt == 4'h0 && first) begin
      next_wp_lat = write_protect;
    end
  end

  always_ff @(negedge scl_in or posedge rst) begin
    if (rst) begin
      sda_oe_n <= 1'b1;
      sda_out  <= 1'b0;
      wp_lat   <= 1'b0;
    end else begin
      sda_oe_n <= next_oe_n;
      sda_out  <= 1'b0;
      wp_lat   <= next_wp_lat;
    end
  end

  // ==========================================================
  // System side: programming cycle timer
  logic          prog_seen;
  logic          prog_evt;
  logic [TW-1:0] timer;
  logic [TW-1:0] next_timer;
  logic          next_busy;

  assign prog_evt = prog_sync != prog_seen;

  always_comb begin
    next_timer = timer;
    next_busy  = busy;
    if (prog_evt) begin
      next_busy  = 1'b1;
      next_timer = TW'(WR_CYCLES - 1);
    end else if (busy) begin
      if (timer == '0) begin
        next_busy = 1'b0;
      end else begin
        next_timer = timer - 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prog_seen <= 1'b0;
      timer     <= '0;
      busy      <= 1'b0;
    end else if (ce) begin
      prog_seen <= prog_sync;
      timer     <= next_timer;
      busy      <= next_busy;
    end
  end

  // ==========================================================
  // Checks
  chk_ack_ninth_clock: assert property (@(posedge scl_in) disable iff (rst)
    (cnt == `EES_BIT_ACK && ack_go) |-> !sda_oe_n)
    else $error("acknowledge not driven in ninth clock");

  chk_busy_no_ack: assert property (@(posedge scl_in) disable iff (rst)
    (state == st_dev && cnt == `EES_BIT_LAST && busy_s && !is_start) |=> (!ack_go && state == st_idle))
    else $error("address acknowledged while programming");

  chk_type_code: assert property (@(posedge scl_in) disable iff (rst)
    (state == st_dev && cnt == `EES_BIT_LAST && !is_start && byte_in[7:4] != `EES_TYPE_CODE)
    |=> (state == st_idle && sda_oe_n))
    else $error("foreign type code answered");

  chk_select_pins: assert property (@(posedge scl_in) disable iff (rst)
    (state == st_dev && cnt == `EES_BIT_LAST && !is_start
     && (byte_in[`EES_DEV_CS_LO] != chip_select_low_pin
         || byte_in[`EES_DEV_CS_HI] != chip_select_high_pin)) |=> (!ack_go && state == st_idle))
    else $error("chip select mismatch answered");

  chk_page_wrap: assert property (@(posedge scl_in) disable iff (rst)
    (mem_we && !is_start) |=> (addr[AW-1:PW] == $past(addr[AW-1:PW])
     && addr[PW-1:0] == $past(addr[PW-1:0]) + 8'h01))
    else $error("page write left its page");

  chk_protect_refuse: assert property (@(posedge scl_in) disable iff (rst)
    (state == st_wdata && cnt == `EES_BIT_LAST && first && wp_lat && !is_start)
    |-> !mem_we ##1 (!ack_go && state == st_idle))
    else $error("protected write accepted");

  chk_release_ninth: assert property (@(posedge scl_in) disable iff (rst)
    (state == st_rdata && cnt == `EES_BIT_ACK && !ack_go) |-> sda_oe_n)
    else $error("data line held in read ninth clock");

  chk_read_wrap: assert property (@(posedge scl_in) disable iff (rst)
    (state == st_rdata && cnt == `EES_BIT_ACK && !is_start && (first || !sda_in) && (&addr))
    |=> addr == '0)
    else $error("read counter did not wrap");

  chk_prog_starts: assert property (@(posedge clock) disable iff (rst)
    (prog_evt && ce) |=> busy)
    else $error("stop after write did not start programming");

  chk_busy_length: assert property (@(posedge clock) disable iff (rst)
    (ce && $rose(busy)) |-> busy [*8])
    else $error("programming cycle ended early");
endmodule

// ===== ees_master.sv
// Behavioural two-wire bus master driving clock and conditions
`timescale 1ns/1ns
module ees_master (
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  // ==========================================
  // Idle bus: clock stands high between frames
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end
  task automatic start_c();
    if (!scl) begin
      sda_m = 1'b1;
      #30 scl = 1'b1;
    end
    #20 sda_m = 1'b0;
    #20 scl = 1'b0;
    #10;
  endtask
  task automatic stop_c();
    sda_m = 1'b0;
    #30 scl = 1'b1;
    #20 sda_m = 1'b1;
    #40;
  endtask
  // Data moves only with the clock low; sampled on the rise
  task automatic pulse(output logic s);
    #30 scl = 1'b1;
    s = sda;
    #40 scl = 1'b0;
    #10;
  endtask
  task automatic wb(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_m = d[i];
      pulse(s);
    end
    sda_m = 1'b1;
    pulse(s);
    ack = !s;
  endtask
  task automatic rb(input logic ack, output logic [7:0] d);
    logic s;
    sda_m = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      pulse(s);
      d[i] = s;
    end
    sda_m = !ack;
    pulse(s);
  endtask
endmodule

// ===== tb_i2c_serial_eeprom_slave.sv
// Self-checking bench of the two-wire serial memory slave
`timescale 1ns/1ns
`include "ees_cfg.svh"
module tb_i2c_serial_eeprom_slave;
  import ees_pkg::*;
  localparam int WR = `EES_WR_MIN;
  logic        clock;
  logic        rst;
  logic        ce;
  logic        scl;
  logic        sda_m;
  wire logic   sda;
  logic        sda_out;
  logic        sda_oe_n;
  logic        chip_select_low_pin;
  logic        chip_select_high_pin;
  logic        write_protect;
  logic        busy;
  logic [7:0]  mem [logic [16:0]];
  logic [16:0] ctr;
  logic [16:0] a;
  logic        ok;
  int          fail_count;
  int          n_checks;

  assign sda = sda_m & (sda_oe_n | sda_out);

  ees_slave #(.WR_CYCLES(WR)) i_ees_slave (.clock(clock), .rst(rst), .ce(ce), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .chip_select_low_pin(chip_select_low_pin),
    .chip_select_high_pin(chip_select_high_pin), .write_protect(write_protect), .busy(busy));
  ees_master i_ees_master (.scl(scl), .sda_m(sda_m), .sda(sda));

  // ==========================================
  // Helpers
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  function automatic logic [7:0] exp_b(input logic [16:0] x);
    return mem.exists(x) ? mem[x] : `EES_ERASED;
  endfunction
  function automatic logic [7:0] dev(input logic top, input logic rw);
    return {`EES_TYPE_CODE, chip_select_high_pin, chip_select_low_pin, top, rw};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic hdr(input logic [16:0] x, output logic good);
    logic k0, k1, k2;
    i_ees_master.start_c();
    i_ees_master.wb(dev(x[16], 1'b0), k0);
    i_ees_master.wb(x[15:8], k1);
    i_ees_master.wb(x[7:0], k2);
    good = k0 & k1 & k2;
  endtask
  task automatic prog_chk(input logic exp);
    logic seen;
    logic k;
    seen = 1'b0;
    for (int t = 0; t < 30 && !seen; t++) @(posedge clock) seen = (busy === 1'b1);
    check(8'(seen), 8'(exp));
    if (exp) begin
      hdr(17'h0, k);
      i_ees_master.stop_c();
      check(8'(k), 8'h0);
      for (int t = 0; t < 20 && !k; t++) begin
        hdr(17'h0, k);
        i_ees_master.stop_c();
      end
      check(8'(k), 8'h1);
    end
  endtask
  task automatic wr(input logic [16:0] x, input int n, input logic prot);
    logic good, k;
    logic [7:0] d;
    @(posedge clock) write_protect <= prot;
    hdr(x, good);
    check(8'(good), 8'h1);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      i_ees_master.wb(d, k);
      check(8'(k), 8'(!prot));
      if (!prot) mem[{x[16:8], x[7:0] + 8'(i)}] = d;
    end
    i_ees_master.stop_c();
    prog_chk(!prot);
  endtask
  task automatic rd(input logic [16:0] x, input logic sel, input int n);
    logic good, k;
    logic [7:0] d;
    if (sel) begin
      hdr(x, good);
      check(8'(good), 8'h1);
      ctr = x;
    end
    i_ees_master.start_c();
    i_ees_master.wb(dev(ctr[16], 1'b1), k);
    check(8'(k), 8'h1);
    for (int i = 0; i < n; i++) begin
      i_ees_master.rb(i < n - 1, d);
      check(d, exp_b(ctr));
      ctr = ctr + 17'h1;
    end
    i_ees_master.stop_c();
  endtask

  // ==========================================
  // Main sequence
  initial begin
    logic k;
    void'($urandom(18));
    rst = 1'b1;
    ce = 1'b1;
    write_protect = 1'b0;
    chip_select_low_pin = 1'b0;
    chip_select_high_pin = 1'b0;
    fail_count = 0;
    n_checks = 0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    {chip_select_high_pin, chip_select_low_pin} <= 2'($urandom_range(3));
    repeat (5) @(posedge clock);
    a = 17'($urandom);
    rd(a, 1'b1, 2);
    i_ees_master.start_c();
    i_ees_master.wb(8'hb0 | (dev(1'b0, 1'b0) & 8'h0f), k);
    check(8'(k), 8'h0);
    i_ees_master.stop_c();
    i_ees_master.start_c();
    i_ees_master.wb(dev(1'b0, 1'b0) ^ 8'h0c, k);
    check(8'(k), 8'h0);
    i_ees_master.stop_c();
    wr(a, 1, 1'b0);
    rd(a, 1'b1, 1);
    a = {a[16:8], 8'hfe};
    wr(a, 3, 1'b0);
    rd(a, 1'b1, 3);
    rd({a[16:8], 8'h00}, 1'b1, 1);
    wr(17'h0, 1, 1'b0);
    rd(17'h1ffff, 1'b1, 2);
    rd(17'h0, 1'b0, 1);
    wr(a, 1, 1'b1);
    rd(a, 1'b1, 1);
    @(posedge clock) write_protect <= 1'b0;
    hdr(a, ok);
    check(8'(ok), 8'h1);
    i_ees_master.stop_c();
    prog_chk(1'b0);
    // ==========================================
    // Enable low stretches programming; reset mid-cycle restores the erased array
    hdr(a, ok);
    i_ees_master.wb(8'h5a, k);
    check(8'(ok & k), 8'h1);
    i_ees_master.stop_c();
    repeat (8) @(posedge clock);
    check(8'(busy), 8'h1);
    ce <= 1'b0;
    repeat (2 * WR) @(posedge clock);
    check(8'(busy), 8'h1);
    ce  <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    check({5'h00, sda_out, busy, sda_oe_n}, 8'h01);
    rst <= 1'b0;
    mem.delete();
    repeat (5) @(posedge clock);
    rd(a, 1'b1, 1);
    wrap_up();
  end

  initial begin
    #2000000;
    fail_count++;
    wrap_up();
  end
endmodule
